// ===== core/i2c_host_pkg.sv
// Constants and types for the register-pointer bus host.
// Assumes a 40 MHz system clock and a fast-mode two-wire bus.
package i2c_host_pkg;

  // Timing
  localparam int MCLK_PERIOD_NS = 25;
  localparam int SCL_QUARTER_NS = 625;
  localparam int QUARTER_CYC    = (SCL_QUARTER_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  // Direction bit
  localparam logic RW_WRITE = 1'h0;
  localparam logic RW_READ  = 1'h1;

  // Command operations
  localparam logic [1:0] OP_WRITE    = 2'h0;
  localparam logic [1:0] OP_READ     = 2'h1;
  localparam logic [1:0] OP_PTR_READ = 2'h2;

  // Far-side wide register addresses
  localparam logic [7:0] REG_RESULT_FIRST = 8'h01;
  localparam logic [7:0] REG_RESULT_LAST  = 8'h04;
  localparam logic [7:0] REG_CONFIG       = 8'h09;
  localparam logic [7:0] REG_LIMIT_FIRST  = 8'h0B;
  localparam logic [7:0] REG_LIMIT_LAST   = 8'h25;

  // Bit slot of the acknowledge
  localparam logic [3:0] ACK_SLOT = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_START  = 3'h1,
    ST_BIT    = 3'h2,
    ST_STOP   = 3'h3,
    ST_HOLD   = 3'h4,
    ST_RSTART = 3'h5
  } state_t;

  typedef enum logic [2:0] {
    SP_ADDR_W  = 3'h0,
    SP_PTR     = 3'h1,
    SP_DATA_HI = 3'h2,
    SP_DATA_LO = 3'h3,
    SP_ADDR_R  = 3'h4,
    SP_READ    = 3'h5
  } step_t;

  // Two data bytes for wide registers, one for all others
  function automatic logic reg_is_wide(input logic [7:0] p);
    return (p >= REG_RESULT_FIRST && p <= REG_RESULT_LAST) || (p == REG_CONFIG) ||
           (p >= REG_LIMIT_FIRST && p <= REG_LIMIT_LAST);
  endfunction

endpackage

// ===== core/i2c_pin_sync.sv
// Three-stage synchroniser for one bus pin.
// Output moves only when the second and third stages agree.
`timescale 1ns/1ps
module i2c_pin_sync (
  // System
  input  wire logic clk,
  input  wire logic rst,
  // Pin
  input  wire logic d,
  output logic      q
);
  logic ff1_q;
  logic ff2_q;
  logic ff3_q;

  // Idle bus level is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ff1_q <= 1'h1;
      ff2_q <= 1'h1;
      ff3_q <= 1'h1;
    end else begin
      ff1_q <= d;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= 1'h1;
    end else if (ff2_q == ff3_q) begin
      q <= ff3_q;
    end
  end
endmodule

// ===== core/i2c_quarter_tick.sv
// Free-running quarter-bit strobe for the bus clock.
// Assumes the package quarter count fits eight bits.
`timescale 1ns/1ps
module i2c_quarter_tick
  import i2c_host_pkg::*;
(
  // System
  input  wire logic clk,
  input  wire logic rst,
  // Strobe
  output logic      tick
);
  localparam logic [7:0] LAST_CNT = 8'(QUARTER_CYC - 1);

  logic [7:0] cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
      tick  <= 1'h0;
    end else begin
      tick  <= (cnt_q == LAST_CNT);
      cnt_q <= (cnt_q == LAST_CNT) ? 8'h00 : cnt_q + 8'h01;
    end
  end
endmodule

// ===== core/i2c_ptr_host.sv
// Bus host that writes register pointers and data and reads back
// single bytes or byte pairs from the selected register.
// Assumes open-drain pins resolved outside; SCL and SDA are async.
// Behaviour
// R1: Open with start, address, direction low to write pointer or data.
// R2: Read uses address with direction high; device then supplies bytes.
// R3: Device acknowledges address, pointer and data bytes; host releases SDA.
// R4: After a register's data, next byte in same write is a new pointer.
// R5: Wide register data goes high byte first, then low byte.
// R6: Pointer must be written before reading a register.
// R7: Device repeats the same register on every read; pointer never advances.
// R8: Host acknowledges every read byte except the last, then stops.
// R9: Device releases SDA once the host declines a byte.
// R10: Pointer survives the end of a transaction.
// R11: New register needs new pointer write before its reads.
// R12: Wide registers return byte pairs while the host keeps acknowledging.
// R13: Host pulls SDA low in acknowledge slot for all but final byte.
// R14: Every transaction ends with stop after the last acknowledge slot.
// R15: Pointer write then repeated start and read address switch to reading.
// R16: Registers 0x00, 0x05-0x08, 0x0A, 0x26, 0x27 take one data byte.
// R17: Registers 0x01-0x04, 0x09, 0x0B-0x25 are wide, two data bytes.
// R18: Device address comes from three three-level straps, 0x61 to 0x7B.
// R19: Device ignores transactions whose address byte does not match.
`timescale 1ns/1ps
module i2c_ptr_host
  import i2c_host_pkg::*;
(
  // System
  input  wire logic        MCLK,
  input  wire logic        RST,
  // Command
  input  wire logic        CMD_VALID,
  input  wire logic [1:0]  CMD_OP,
  input  wire logic        CMD_CHAIN,
  input  wire logic [6:0]  CMD_DEV,
  input  wire logic [7:0]  CMD_PTR,
  input  wire logic [15:0] CMD_DATA,
  input  wire logic        CMD_WITH_DATA,
  input  wire logic [3:0]  CMD_COUNT,
  output logic             CMD_READY,
  // Results
  output logic             RD_VALID,
  output logic [7:0]       RD_DATA,
  output logic             DONE,
  output logic             NACK_ERR,
  output logic [7:0]       CUR_PTR,
  // Bus pins
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE
);
  state_t      state_q;
  step_t       step_q;
  logic [1:0]  phase_q;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q;
  logic [6:0]  dev_q;
  logic [7:0]  wptr_q;
  logic [15:0] data_q;
  logic        with_data_q;
  logic        chain_q;
  logic        read_after_q;
  logic [4:0]  rd_left_q;
  logic        scl_s;
  logic        sda_s;
  logic        tick;
  logic        accept;
  logic        ptr_wide;
  logic [4:0]  rd_bytes;
  logic [3:0]  rd_vals;

  i2c_pin_sync u_scl_sync (
    .clk (MCLK),
    .rst (RST),
    .d   (SCL_IN),
    .q   (scl_s)
  );

  i2c_pin_sync u_sda_sync (
    .clk (MCLK),
    .rst (RST),
    .d   (SDA_IN),
    .q   (sda_s)
  );

  i2c_quarter_tick u_tick (
    .clk  (MCLK),
    .rst  (RST),
    .tick (tick)
  );

  assign accept = CMD_VALID && CMD_READY;
  // R17: width picks byte count per value
  assign ptr_wide = reg_is_wide((CMD_OP == OP_READ) ? CUR_PTR : CMD_PTR);
  // Zero count still means one whole value, a full pair on wide registers
  assign rd_vals  = (CMD_COUNT == 4'h0) ? 4'h1 : CMD_COUNT;
  assign rd_bytes = ptr_wide ? {rd_vals, 1'h0} : {1'h0, rd_vals};

  // Open drain: only the enables move
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      SCL_OUT <= 1'h0;
      SDA_OUT <= 1'h0;
    end else begin
      SCL_OUT <= 1'h0;
      SDA_OUT <= 1'h0;
    end
  end

  // Command fields
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      dev_q        <= 7'h00;
      wptr_q       <= 8'h00;
      data_q       <= 16'h0000;
      with_data_q  <= 1'h0;
      chain_q      <= 1'h0;
      read_after_q <= 1'h0;
    end else if (accept) begin
      if (state_q == ST_IDLE) begin
        dev_q <= CMD_DEV;
      end
      wptr_q       <= CMD_PTR;
      data_q       <= CMD_DATA;
      with_data_q  <= CMD_WITH_DATA && (CMD_OP == OP_WRITE);
      chain_q      <= CMD_CHAIN && (CMD_OP == OP_WRITE);
      // R11: new register via pointer write
      read_after_q <= (CMD_OP == OP_PTR_READ);
    end
  end

  // R10: host mirrors the kept pointer
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      CUR_PTR <= 8'h00;
    end else if (tick && state_q == ST_BIT && step_q == SP_PTR && bit_q == ACK_SLOT &&
                 phase_q == 2'h3 && !NACK_ERR) begin
      CUR_PTR <= wptr_q;
    end
  end

  // Sequencer
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_q   <= ST_IDLE;
      step_q    <= SP_ADDR_W;
      phase_q   <= 2'h0;
      bit_q     <= 4'h0;
      sh_q      <= 8'h00;
      rd_left_q <= 5'h00;
      SCL_OE    <= 1'h0;
      SDA_OE    <= 1'h0;
      CMD_READY <= 1'h1;
      RD_VALID  <= 1'h0;
      RD_DATA   <= 8'h00;
      DONE      <= 1'h0;
      NACK_ERR  <= 1'h0;
    end else begin
      RD_VALID <= 1'h0;
      DONE     <= 1'h0;
      if (accept) begin
        CMD_READY <= 1'h0;
        NACK_ERR  <= 1'h0;
        rd_left_q <= rd_bytes;
        phase_q   <= 2'h0;
        bit_q     <= 4'h0;
        if (state_q == ST_IDLE) begin
          // R1: write opens with direction low
          // R2: bare read opens with direction high
          state_q <= ST_START;
          step_q  <= (CMD_OP == OP_READ) ? SP_ADDR_R : SP_ADDR_W;
          sh_q    <= {CMD_DEV, (CMD_OP == OP_READ) ? RW_READ : RW_WRITE};
        end else if (CMD_OP == OP_READ) begin
          state_q <= ST_RSTART;
        end else begin
          // R4: held write goes on with a new pointer
          state_q <= ST_BIT;
          step_q  <= SP_PTR;
          sh_q    <= CMD_PTR;
        end
      end else if (tick) begin
        case (state_q)
          ST_IDLE, ST_HOLD: begin
            phase_q <= 2'h0;
          end
          ST_START: begin
            if (phase_q == 2'h0) begin
              SDA_OE  <= 1'h1;
              phase_q <= 2'h1;
            end else begin
              SCL_OE  <= 1'h1;
              phase_q <= 2'h0;
              state_q <= ST_BIT;
            end
          end
          ST_RSTART: begin
            // R15: repeated start before the read address
            case (phase_q)
              2'h0: begin
                SDA_OE  <= 1'h0;
                phase_q <= 2'h1;
              end
              2'h1: begin
                SCL_OE  <= 1'h0;
                phase_q <= 2'h2;
              end
              default: begin
                if (scl_s) begin
                  phase_q <= 2'h0;
                  state_q <= ST_START;
                  step_q  <= SP_ADDR_R;
                  sh_q    <= {dev_q, RW_READ};
                end
              end
            endcase
          end
          ST_BIT: begin
            case (phase_q)
              2'h0: begin
                if (bit_q != ACK_SLOT) begin
                  SDA_OE <= (step_q == SP_READ) ? 1'h0 : !sh_q[7];
                end else if (step_q == SP_READ) begin
                  // R8: last byte left unacknowledged
                  // R13: other read bytes acknowledged
                  SDA_OE <= (rd_left_q != 5'h01);
                end else begin
                  // R3: slot left to the device
                  SDA_OE <= 1'h0;
                end
                phase_q <= 2'h1;
              end
              2'h1: begin
                SCL_OE  <= 1'h0;
                phase_q <= 2'h2;
              end
              2'h2: begin
                // Waits out clock stretching
                if (scl_s) begin
                  if (bit_q != ACK_SLOT) begin
                    sh_q <= {sh_q[6:0], sda_s};
                  end else if (step_q != SP_READ) begin
                    NACK_ERR <= sda_s;
                  end
                  phase_q <= 2'h3;
                end
              end
              default: begin
                SCL_OE  <= 1'h1;
                phase_q <= 2'h0;
                if (bit_q != ACK_SLOT) begin
                  bit_q <= bit_q + 4'h1;
                end else begin
                  bit_q <= 4'h0;
                  if (step_q != SP_READ && NACK_ERR) begin
                    // R19: unanswered byte ends the transfer
                    state_q <= ST_STOP;
                  end else begin
                    case (step_q)
                      SP_ADDR_W: begin
                        step_q <= SP_PTR;
                        sh_q   <= wptr_q;
                      end
                      SP_PTR: begin
                        if (with_data_q) begin
                          // R5: high byte first
                          // R16: narrow register takes one byte
                          step_q <= reg_is_wide(wptr_q) ? SP_DATA_HI : SP_DATA_LO;
                          sh_q   <= reg_is_wide(wptr_q) ? data_q[15:8] : data_q[7:0];
                        end else if (read_after_q) begin
                          // R6: pointer written, now read
                          state_q <= ST_RSTART;
                        end else if (chain_q) begin
                          state_q   <= ST_HOLD;
                          CMD_READY <= 1'h1;
                          DONE      <= 1'h1;
                        end else begin
                          state_q <= ST_STOP;
                        end
                      end
                      SP_DATA_HI: begin
                        step_q <= SP_DATA_LO;
                        sh_q   <= data_q[7:0];
                      end
                      SP_DATA_LO: begin
                        if (chain_q) begin
                          state_q   <= ST_HOLD;
                          CMD_READY <= 1'h1;
                          DONE      <= 1'h1;
                        end else begin
                          state_q <= ST_STOP;
                        end
                      end
                      SP_ADDR_R: begin
                        step_q <= SP_READ;
                      end
                      SP_READ: begin
                        // R12: pairs keep coming while acknowledged
                        RD_VALID  <= 1'h1;
                        RD_DATA   <= sh_q;
                        rd_left_q <= rd_left_q - 5'h01;
                        if (rd_left_q == 5'h01) begin
                          state_q <= ST_STOP;
                        end
                      end
                      default: begin
                        state_q <= ST_STOP;
                      end
                    endcase
                  end
                end
              end
            endcase
          end
          ST_STOP: begin
            // R14: stop closes every transaction
            case (phase_q)
              2'h0: begin
                SDA_OE  <= 1'h1;
                phase_q <= 2'h1;
              end
              2'h1: begin
                SCL_OE  <= 1'h0;
                phase_q <= 2'h2;
              end
              2'h2: begin
                if (scl_s) begin
                  phase_q <= 2'h3;
                end
              end
              default: begin
                SDA_OE    <= 1'h0;
                phase_q   <= 2'h0;
                state_q   <= ST_IDLE;
                CMD_READY <= 1'h1;
                DONE      <= 1'h1;
              end
            endcase
          end
          default: begin
            state_q <= ST_STOP;
          end
        endcase
      end
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence s_ack_slot_high;
    state_q == ST_BIT && bit_q == ACK_SLOT && phase_q == 2'h2 && scl_s;
  endsequence

  sequence s_stop_last;
    state_q == ST_STOP && phase_q == 2'h3 && tick;
  endsequence

  property p_dev_ack_free;
    s_ack_slot_high and (step_q != SP_READ) |-> !SDA_OE;
  endproperty
  a_dev_ack_free: assert property (p_dev_ack_free) // R3
    else $error("host drove SDA in device acknowledge slot");

  property p_write_dir;
    $rose(state_q == ST_START) && step_q == SP_ADDR_W |-> sh_q == {dev_q, RW_WRITE};
  endproperty
  a_write_dir: assert property (p_write_dir) // R1
    else $error("write address byte lacks low direction bit");

  property p_read_dir;
    $rose(state_q == ST_START) && step_q == SP_ADDR_R |-> sh_q[0] == RW_READ;
  endproperty
  a_read_dir: assert property (p_read_dir) // R2
    else $error("read address byte lacks high direction bit");

  property p_last_nack;
    s_ack_slot_high and (step_q == SP_READ) |-> SDA_OE == (rd_left_q != 5'h01);
  endproperty
  a_last_nack: assert property (p_last_nack) // R8
    else $error("read acknowledge does not match byte position");

  property p_stop_end;
    s_stop_last |=> state_q == ST_IDLE && !SDA_OE && !SCL_OE && DONE;
  endproperty
  a_stop_end: assert property (p_stop_end) // R14
    else $error("stop did not leave the bus idle");

  property p_rstart_read;
    $fell(state_q == ST_RSTART) && !RST |-> state_q == ST_START && sh_q == {dev_q, RW_READ};
  endproperty
  a_rstart_read: assert property (p_rstart_read) // R15
    else $error("repeated start not followed by read address");

  property p_hi_then_lo;
    $rose(step_q == SP_DATA_HI) |-> sh_q == data_q[15:8] ##[1:1000] $rose(step_q == SP_DATA_LO);
  endproperty
  a_hi_then_lo: assert property (p_hi_then_lo) // R5
    else $error("wide data not sent high byte then low byte");

  property p_ptr_kept;
    $changed(CUR_PTR) |-> $past(step_q) == SP_PTR;
  endproperty
  a_ptr_kept: assert property (p_ptr_kept) // R10
    else $error("kept pointer changed outside a pointer byte");

  property p_nack_stop;
    tick && state_q == ST_BIT && bit_q == ACK_SLOT && phase_q == 2'h3 &&
    step_q != SP_READ && NACK_ERR |=> state_q == ST_STOP;
  endproperty
  a_nack_stop: assert property (p_nack_stop) // R19
    else $error("unanswered byte not followed by stop");
endmodule

// ===== tb/i2c_dev_model.sv
// Behavioural model of the register-pointer device on the two-wire bus.
// Assumes the bench resolves both wires with pull-ups from all enables.
`timescale 1ns/1ps
module i2c_dev_model #(
  parameter logic [6:0] DEV_ADDR = 7'h6D
) (
  // Bus wires
  input  wire logic scl,
  input  wire logic sda,
  // Test control
  input  wire logic slow,
  // Open-drain pulls
  output logic      sda_pull,
  output logic      scl_pull
);
  logic [15:0] mem [0:63];
  logic [7:0]  ptr, sh, hold, out;
  logic        act, first, sel, rd, tx, hi;
  logic [1:0]  ph;
  int          cnt;

  function automatic logic is_wide(input logic [7:0] p);
    return (p >= 8'h01 && p <= 8'h04) || p == 8'h09 || (p >= 8'h0B && p <= 8'h25);
  endfunction

  initial begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    act = 1'b0;
    tx = 1'b0;
    ptr = 8'h00;
    for (int i = 0; i < 64; i++) mem[i] = {8'(i) ^ 8'hA5, 8'(i) + 8'h3C};
  end

  always @(negedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b1;
      first = 1'b1;
      cnt = 0;
      ph = 2'h0;
      tx = 1'b0;
      sda_pull = 1'b0;
    end
  end

  always @(posedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b0;
      tx = 1'b0;
      sda_pull = 1'b0;
    end
  end

  always @(posedge scl) begin
    if (act) begin
      if (cnt < 8) sh = {sh[6:0], sda};
      else if (tx) tx = !sda;
      cnt = cnt + 1;
    end
  end

  always @(negedge scl) begin
    if (act) begin
      sda_pull = 1'b0;
      if (cnt == 8) begin
        if (first) begin
          sel = (sh[7:1] == DEV_ADDR);
          rd = sh[0];
          tx = sel && sh[0];
          hi = 1'b1;
        end else if (sel && !rd) begin
          if (ph == 2'h0) begin
            ptr = sh;
            ph = is_wide(sh) ? 2'h1 : 2'h2;
          end else if (ph == 2'h1) begin
            hold = sh;
            ph = 2'h2;
          end else begin
            mem[ptr[5:0]] = is_wide(ptr) ? {hold, sh} : {8'h00, sh};
            ph = 2'h0;
          end
        end
        sda_pull = sel && (first || !rd);
        first = 1'b0;
        // Slow answer by holding the clock low
        if (slow) begin
          scl_pull = 1'b1;
          #1000 scl_pull = 1'b0;
        end
      end else if (cnt == 9) begin
        cnt = 0;
        if (tx) begin
          out = (is_wide(ptr) && hi) ? mem[ptr[5:0]][15:8] : mem[ptr[5:0]][7:0];
          if (is_wide(ptr)) hi = !hi;
        end
      end
      if (cnt < 8) sda_pull = tx && !out[7 - cnt];
    end
  end
endmodule

// ===== tb/i2c_ptr_host_tb.sv
// Self-checking bench for the register-pointer bus host.
// Assumes the device model answers on a pulled-up two-wire bus.
`timescale 1ns/1ps
module i2c_ptr_host_tb;
  import i2c_host_pkg::*;
  localparam logic [6:0] DEV = 7'h6D;

  logic        mclk, rst, cmd_valid, cmd_chain, cmd_with_data;
  logic [1:0]  cmd_op;
  logic [6:0]  cmd_dev;
  logic [7:0]  cmd_ptr, rd_data, cur_ptr;
  logic [15:0] cmd_data;
  logic [3:0]  cmd_count;
  logic        cmd_ready, rd_valid, done, nack_err;
  logic        scl_oe, sda_oe, dev_sda, dev_scl, slow, scl_out, sda_out;
  logic [15:0] shadow [0:63];
  logic [7:0]  got [$];
  logic [31:0] seed;
  int          n_fail, total_checks;
  wire         scl_w = !(scl_oe || dev_scl);
  wire         sda_w = !(sda_oe || dev_sda);

  i2c_ptr_host i_dut (
    .MCLK(mclk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
    .CMD_CHAIN(cmd_chain), .CMD_DEV(cmd_dev), .CMD_PTR(cmd_ptr), .CMD_DATA(cmd_data),
    .CMD_WITH_DATA(cmd_with_data), .CMD_COUNT(cmd_count), .CMD_READY(cmd_ready),
    .RD_VALID(rd_valid), .RD_DATA(rd_data), .DONE(done), .NACK_ERR(nack_err),
    .CUR_PTR(cur_ptr), .SCL_IN(scl_w), .SCL_OUT(scl_out), .SCL_OE(scl_oe), .SDA_IN(sda_w),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe)
  );

  i2c_dev_model #(.DEV_ADDR(DEV)) i_dev (
    .scl(scl_w), .sda(sda_w), .slow(slow), .sda_pull(dev_sda), .scl_pull(dev_scl)
  );

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 16; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction

  function automatic logic is_wide(input logic [7:0] p);
    return (p >= 8'h01 && p <= 8'h04) || p == 8'h09 || (p >= 8'h0B && p <= 8'h25);
  endfunction

  function automatic logic [7:0] exp_byte(input logic [7:0] p, input int i);
    if (is_wide(p) && i % 2 == 0) return shadow[p[5:0]][15:8];
    return shadow[p[5:0]][7:0];
  endfunction

  task automatic test_done();
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string what);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask

  // Called at a falling edge; returns at the falling edge showing DONE
  task automatic run(input logic [1:0] op, input logic ch, input logic [6:0] dv,
                     input logic [7:0] p, input logic [15:0] d, input logic wd,
                     input logic [3:0] c);
    int n;
    got.delete();
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 100) begin
      n_fail++;
      $display("BAD %0t never ready", $time);
      test_done();
    end
    {cmd_op, cmd_chain, cmd_dev, cmd_ptr, cmd_data, cmd_with_data} = {op, ch, dv, p, d, wd};
    cmd_count = c;
    cmd_valid = 1'b1;
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40000) begin
      if (rd_valid === 1'b1) got.push_back(rd_data);
      @(negedge mclk);
      n++;
    end
    if (n >= 40000) begin
      n_fail++;
      $display("BAD %0t no completion", $time);
      test_done();
    end
  endtask

  task automatic wr(input logic ch, input logic [7:0] p, input logic [15:0] d, input logic wd);
    run(OP_WRITE, ch, DEV, p, d, wd, 4'h0);
    if (wd) shadow[p[5:0]] = is_wide(p) ? d : {8'h00, d[7:0]};
    chk(cur_ptr, p, "pointer");
    chk({7'h00, nack_err}, 8'h00, "write ack");
  endtask

  task automatic rd(input logic [1:0] op, input logic [7:0] p, input logic [3:0] c);
    int nv;
    run(op, 1'b0, DEV, p, 16'h0000, 1'b0, c);
    nv = (c == 4'h0) ? 1 : int'(c);
    if (is_wide(p)) nv = nv * 2;
    chk(8'(got.size()), 8'(nv), "byte count");
    for (int i = 0; i < got.size(); i++) chk(got[i], exp_byte(p, i), "read data");
    chk({4'h0, scl_out, sda_out, scl_w, sda_w}, 8'h03, "idle bus");
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    $display("BAD %0t run limit", $time);
    test_done();
  end

  initial begin
    logic [7:0] p;
    {rst, cmd_valid, cmd_op, cmd_chain, cmd_dev, cmd_ptr} = {1'b1, 1'b0, 2'h0, 1'b0, DEV, 8'h00};
    {cmd_data, cmd_with_data, cmd_count, slow} = {16'h0000, 1'b0, 4'h0, 1'b0};
    n_fail = 0;
    total_checks = 0;
    seed = 32'h0001_17D4;
    for (int i = 0; i < 64; i++) shadow[i] = {8'(i) ^ 8'hA5, 8'(i) + 8'h3C};
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    wr(1'b1, 8'h0A, 16'h005A, 1'b1);
    wr(1'b1, 8'h09, 16'hC3E1, 1'b1);
    rd(OP_PTR_READ, 8'h0A, 4'h1);
    rd(OP_PTR_READ, 8'h09, 4'h3);
    rd(OP_READ, 8'h09, 4'h0);
    slow = 1'b1;
    wr(1'b1, 8'h26, 16'h0077, 1'b1);
    rd(OP_READ, 8'h26, 4'h2);
    slow = 1'b0;
    run(OP_WRITE, 1'b0, DEV ^ 7'h01, 8'h05, 16'h0011, 1'b1, 4'h0);
    chk({7'h00, nack_err}, 8'h01, "foreign address");
    chk(cur_ptr, 8'h26, "pointer kept");
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      p = seed[7:0] % 8'h28;
      slow = seed[8];
      wr(1'b0, p, seed[31:16], seed[9] | (k == 0));
      rd(OP_PTR_READ, p, {2'b00, seed[11:10]});
    end
    test_done();
  end
endmodule
